// File: bench/gain_ctrl_model.sv
/*
 Downstream gain-control model: watches the flag bits embedded in the
 complex output words. Assumes out_valid and iq_out share its clock.
*/
`timescale 1ns/10ps

module gain_ctrl_model #(
    parameter int QUIET_LEN = 16
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              out_valid,
    input  wire ovr_pkg::iq_word_s iq_out,
    output logic                   gain_down,
    output logic                   gain_up
);
    import ovr_pkg::*;
    int quiet;

    // ==========================================================
    // Gain decisions
    // Cut gain on the high flag, raise it after a long quiet low flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gain_down <= 1'b0;
            gain_up   <= 1'b0;
            quiet     <= 0;
        end else if (out_valid) begin
            gain_down <= iq_out.i_word[0];
            quiet     <= iq_out.q_word[0] ? 0 : quiet + 1;
            gain_up   <= (quiet >= QUIET_LEN) && !iq_out.q_word[0];
        end
    end
endmodule

// File: bench/tb_adc_over_range_detector.sv
/*
 Testbench for the over-range detector: APB registers, sample streams,
 windows and interrupts. Assumes design sources and the model come first.
*/
`timescale 1ns/10ps
`include "ovr_regs.svh"

module tb_adc_over_range_detector;
    import ovr_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        raw_valid = 1'b0;
    logic [11:0] raw_sample = 12'h000;
    logic        iq_valid = 1'b0;
    iq_s         iq_in = '0;
    logic        out_valid;
    iq_word_s    iq_out;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        gain_down;
    logic        gain_up;
    logic [31:0] rd;
    logic        err;
    int          num_errors = 0;
    int          compares = 0;
    logic [11:0] codes [6] = '{12'hFFF, 12'hFF0, 12'hFEF, 12'h800, 12'h010, 12'h000};

    // ==========================================================
    // Clock, design and far-side model
    always #2.5 clk = ~clk;

    adc_over_range_detector i_adc_over_range_detector (
        .clk(clk), .reset(reset), .raw_valid(raw_valid), .raw_sample(raw_sample),
        .iq_valid(iq_valid), .iq_in(iq_in), .out_valid(out_valid), .iq_out(iq_out),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    gain_ctrl_model i_gain_ctrl_model (
        .clk(clk), .reset(reset), .out_valid(out_valid), .iq_out(iq_out),
        .gain_down(gain_down), .gain_up(gain_up));

    // ==========================================================
    // Helpers
    // Expected upper 8 magnitude bits of a raw code
    function automatic logic [7:0] mag8(input logic [11:0] r);
        logic [11:0] s;
        s = r ^ 12'h800;
        s = s[11] ? (~s + 12'h001) : s;
        if (s > 12'h7FF) s = 12'h7FF;
        return s[10:3];
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] expv);
        compares++;
        if (seen !== expv) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("pready", {31'h0, pready}, 32'h1);
    endtask

    task automatic raws(input logic [11:0] x, input int cnt);
        repeat (cnt) begin
            @(posedge clk);
            raw_valid  <= 1'b1;
            raw_sample <= x;
        end
        @(posedge clk);
        raw_valid <= 1'b0;
    endtask

    // Send one complex sample and compare the word that comes back
    task automatic iq_chk(input logic hi, input logic lo);
        @(posedge clk);
        iq_valid <= 1'b1;
        iq_in    <= '{i: 15'h2A5A, q: 15'h55A5};
        @(posedge clk);
        iq_valid <= 1'b0;
        @(negedge clk);
        chk("out_valid", {31'h0, out_valid}, 32'h1);
        chk("iq_out", iq_out, {15'h2A5A, hi, 15'h55A5, lo});
    endtask

    // Close the running window with exponent 0 before the new setting
    task automatic set_ctrl(input logic [7:0] hi, input logic [7:0] lo, input logic [2:0] e);
        apb(1'b1, `OFS_CTRL, {16'h0000, lo, hi});
        raws(12'h800, 1);
        apb(1'b1, `OFS_CTRL, {13'h0000, e, lo, hi});
    endtask

    task automatic reg_chk(input string what, input logic [11:0] a, input logic [31:0] expv);
        apb(1'b0, a, 32'h0);
        chk(what, rd, expv);
    endtask

    task automatic irq_chk(input logic v);
        repeat (2) @(negedge clk);
        chk("irq", {31'h0, irq}, {31'h0, v});
    endtask

    task automatic end_of_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // Watchdog
    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        reg_chk("ctrl", `OFS_CTRL, `CTRL_RST);
        reg_chk("status", `OFS_STATUS, 32'h0);
        reg_chk("int_en", `OFS_INT_EN, 32'h0);
        reg_chk("flags", `OFS_FLAGS, 32'h0);
        // Magnitude table and boundary codes, one-sample windows
        set_ctrl(8'hFE, 8'hFF, 3'h0);
        foreach (codes[k]) begin
            raws(codes[k], 1);
            iq_chk(mag8(codes[k]) >= 8'hFE, mag8(codes[k]) >= 8'hFF);
        end
        // Every window length: a hit in the first sample shows once the last closes it
        for (int e = 0; e < 8; e++) begin
            set_ctrl(8'hE4, 8'h40, e[2:0]);
            raws(12'hFFF, 1);
            if (e > 0) begin
                raws(12'h800, (1 << e) - 2);
                iq_chk(1'b0, 1'b0);
                raws(12'h800, 1);
            end
            iq_chk(1'b1, 1'b1);
        end
        // Far side: cut gain on a high trip, raise it after a quiet low flag
        @(negedge clk);
        chk("gain_down", {31'h0, gain_down}, 32'h1);
        set_ctrl(8'hE4, 8'h40, 3'h0);
        repeat (17) iq_chk(1'b0, 1'b0);
        @(negedge clk);
        chk("gain_up", {31'h0, gain_up}, 32'h1);
        chk("gain_down", {31'h0, gain_down}, 32'h0);
        // Interrupts: sticky status, masking, clearing
        apb(1'b1, `OFS_INT_CLR, 32'h3);
        set_ctrl(8'hE4, 8'h40, 3'h0);
        reg_chk("status", `OFS_STATUS, 32'h0);
        raws(12'hC00, 1);
        reg_chk("flags", `OFS_FLAGS, 32'h2);
        raws(12'hFFF, 1);
        apb(1'b1, `OFS_STATUS, 32'h0);
        reg_chk("status", `OFS_STATUS, 32'h3);
        irq_chk(1'b0);
        apb(1'b1, `OFS_INT_EN, 32'h1);
        irq_chk(1'b1);
        reg_chk("int_en", `OFS_INT_EN, 32'h1);
        apb(1'b1, `OFS_INT_CLR, 32'h1);
        irq_chk(1'b0);
        reg_chk("status", `OFS_STATUS, 32'h2);
        apb(1'b1, `OFS_INT_EN, 32'h2);
        irq_chk(1'b1);
        apb(1'b1, `OFS_INT_CLR, 32'h2);
        irq_chk(1'b0);
        reg_chk("int_clr", `OFS_INT_CLR, 32'h0);
        // Unmapped place refused
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk("wr_err", {31'h0, err}, 32'h1);
        reg_chk("unmapped", 12'h020, 32'h0);
        chk("rd_err", {31'h0, err}, 32'h1);
        end_of_test();
    end
endmodule

// File: rtl/adc_over_range_detector.sv
/*
 Over-range detector: magnitude of raw converter samples checked against two
 thresholds over a window, flags embedded in complex output words, APB
 register slave with sticky interrupt status.
 Assumes raw samples and complex samples are synchronous to clk, one per
 valid cycle, and an APB master in the same clock domain.
*/
`timescale 1ns/10ps
`include "ovr_regs.svh"

module adc_over_range_detector (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             raw_valid,
    input  wire logic [11:0]      raw_sample,
    input  wire logic             iq_valid,
    input  wire ovr_pkg::iq_s     iq_in,
    output logic                  out_valid,
    output ovr_pkg::iq_word_s     iq_out,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    output logic                  irq
);
    import ovr_pkg::*;

    // ==========================================================
    // Declarations
    logic [31:0]        ctrl;
    logic [31:0]        next_ctrl;
    logic [`INT_W-1:0]  status;
    logic [`INT_W-1:0]  next_status;
    logic [`INT_W-1:0]  int_en;
    logic [`INT_W-1:0]  next_int_en;
    logic               next_irq;
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_pslverr;
    logic [6:0]         count;
    logic [6:0]         next_count;
    logic               hi_acc;
    logic               next_hi_acc;
    logic               lo_acc;
    logic               next_lo_acc;
    logic               hi_flag;
    logic               next_hi_flag;
    logic               lo_flag;
    logic               next_lo_flag;
    logic               next_out_valid;
    iq_word_s           next_iq_out;
    thr_t               high_threshold;
    thr_t               low_threshold;
    logic [2:0]         window_exponent;
    logic [6:0]         win_last;
    logic [11:0]        tc;
    logic [10:0]        neg_mag;
    logic [10:0]        mag;
    logic               hit_hi;
    logic               hit_lo;
    logic               win_end;
    logic               wr_take;
    logic               rd_req;
    logic               mapped;
    logic [`INT_W-1:0]  events;
    logic [`INT_W-1:0]  clr;

    // ==========================================================
    // Control fields
    assign high_threshold  = ctrl[`HI_THR_MSB:`HI_THR_LSB];
    assign low_threshold   = ctrl[`LO_THR_MSB:`LO_THR_LSB];
    assign window_exponent = ctrl[`WEXP_MSB:`WEXP_LSB];

    // ==========================================================
    // Magnitude and threshold compare
    always_comb begin
        tc      = {~raw_sample[11], raw_sample[10:0]};
        neg_mag = ~tc[10:0] + `CNT_ONE;
        if (!tc[11]) begin
            mag = tc[10:0];
        end else if (tc[10:0] == `MAG_ZERO) begin
            mag = `MAG_FULL;
        end else begin
            mag = neg_mag[10:0];
        end
        hit_hi = mag[10:3] >= high_threshold;
        hit_lo = mag[10:3] >= low_threshold;
    end

    // ==========================================================
    // Window length: last index is two to the exponent minus one
    assign win_last = `WIN_MASK >> (`EXP_MAX - window_exponent);
    assign win_end  = raw_valid && (count >= win_last);

    // Window accumulation and flag capture
    always_comb begin
        next_count   = count;
        next_hi_acc  = hi_acc;
        next_lo_acc  = lo_acc;
        next_hi_flag = hi_flag;
        next_lo_flag = lo_flag;
        if (win_end) begin
            next_hi_flag = hi_acc | hit_hi;
            next_lo_flag = lo_acc | hit_lo;
            next_hi_acc  = 1'b0;
            next_lo_acc  = 1'b0;
            next_count   = 7'h00;
        end else if (raw_valid) begin
            next_hi_acc  = hi_acc | hit_hi;
            next_lo_acc  = lo_acc | hit_lo;
            next_count   = count + `CNT_ONE;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count   <= 7'h00;
            hi_acc  <= 1'b0;
            lo_acc  <= 1'b0;
            hi_flag <= 1'b0;
            lo_flag <= 1'b0;
        end else begin
            count   <= next_count;
            hi_acc  <= next_hi_acc;
            lo_acc  <= next_lo_acc;
            hi_flag <= next_hi_flag;
            lo_flag <= next_lo_flag;
        end
    end

    // ==========================================================
    // Output words with embedded flags
    always_comb begin
        next_out_valid = iq_valid;
        next_iq_out    = iq_out;
        if (iq_valid) begin
            next_iq_out.i_word = {iq_in.i, hi_flag};
            next_iq_out.q_word = {iq_in.q, lo_flag};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            out_valid <= 1'b0;
            iq_out    <= '0;
        end else begin
            out_valid <= next_out_valid;
            iq_out    <= next_iq_out;
        end
    end

    // ==========================================================
    // APB slave: one wait state, then answer
    assign rd_req  = psel && penable && !pready;
    assign wr_take = psel && penable && pready && pwrite;
    assign mapped  = (paddr == `OFS_CTRL) || (paddr == `OFS_STATUS) ||
                     (paddr == `OFS_INT_CLR) || (paddr == `OFS_INT_EN) ||
                     (paddr == `OFS_FLAGS);

    // Window events, set beats clear
    assign events = {win_end && next_lo_flag, win_end && next_hi_flag};
    assign clr    = (wr_take && paddr == `OFS_INT_CLR) ? pwdata[`INT_W-1:0] : `INT_RST;

    always_comb begin
        next_pready  = rd_req;
        next_pslverr = rd_req && !mapped;
        next_prdata  = 32'h0000_0000;
        next_ctrl    = ctrl;
        next_int_en  = int_en;
        next_status  = (status & ~clr) | events;
        next_irq     = |(next_status & next_int_en);
        if (rd_req && !pwrite) begin
            unique case (paddr)
                `OFS_CTRL:   next_prdata = ctrl;
                `OFS_STATUS: next_prdata = {30'h0000_0000, status};
                `OFS_INT_EN: next_prdata = {30'h0000_0000, int_en};
                `OFS_FLAGS:  next_prdata = {30'h0000_0000, lo_flag, hi_flag};
                default:     next_prdata = 32'h0000_0000;
            endcase
        end
        if (wr_take && paddr == `OFS_CTRL) begin
            next_ctrl = pwdata & `CTRL_MASK;
        end
        if (wr_take && paddr == `OFS_INT_EN) begin
            next_int_en = pwdata[`INT_W-1:0];
        end
        next_irq = |(next_status & next_int_en);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl    <= `CTRL_RST;
            int_en  <= `INT_RST;
            status  <= `INT_RST;
            irq     <= 1'b0;
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            int_en  <= next_int_en;
            status  <= next_status;
            irq     <= next_irq;
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Most negative code saturates
    mag_saturate_a: assert property (
        raw_sample == 12'h000 |-> mag == 11'h7FF)
        else $error("most negative code not saturated");

    // Mid-scale code is zero, near-negative maps to 2032
    mag_table_a: assert property (
        (raw_sample == 12'h800 |-> mag == 11'h000) and
        (raw_sample == 12'h010 |-> mag == 11'h7F0))
        else $error("magnitude table mismatch");

    // A hit mid-window is remembered
    hit_kept_a: assert property (
        raw_valid && hit_hi && !win_end |=> hi_acc)
        else $error("high hit lost inside window");

    // Completed window result
    flag_result_a: assert property (
        win_end |=> hi_flag == ($past(hi_acc) | $past(hit_hi)) &&
                    lo_flag == ($past(lo_acc) | $past(hit_lo)))
        else $error("window flag result wrong");

    // Exponent zero closes a window on each sample
    window_one_a: assert property (
        raw_valid && window_exponent == 3'h0 |-> win_end)
        else $error("one-sample window not closed");

    // Exponent seven: no sample before the last one closes the window
    window_long_a: assert property (
        raw_valid && window_exponent == 3'h7 && count < `WIN_MASK |-> !win_end)
        else $error("128-sample window closed early");

    // Flags hold between windows
    flag_hold_a: assert property (
        !win_end |=> $stable(hi_flag) && $stable(lo_flag))
        else $error("flag changed outside window end");

    // In-phase embedding
    i_embed_a: assert property (
        iq_valid |=> out_valid && iq_out.i_word[15:1] == $past(iq_in.i) &&
                     iq_out.i_word[0] == $past(hi_flag))
        else $error("in-phase word wrong");

    // Quadrature embedding
    q_embed_a: assert property (
        iq_valid |=> iq_out.q_word[15:1] == $past(iq_in.q) &&
                     iq_out.q_word[0] == $past(lo_flag))
        else $error("quadrature word wrong");

    // Interrupt follows enabled status
    irq_level_a: assert property (
        irq == |(status & int_en))
        else $error("interrupt level wrong");

    // Access phase answered on the next edge
    apb_answer_a: assert property (
        psel && penable && !pready |=> pready)
        else $error("access phase not answered");

    // Answer stands one cycle only
    apb_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held too long");

    // Unmapped address answered with an error
    apb_error_a: assert property (
        psel && penable && !pready && !mapped |=> pready && pslverr)
        else $error("unmapped access not refused");

    // Window event sets its sticky bit, also against a clear
    status_set_a: assert property (
        events != `INT_RST |=> (status & $past(events)) == $past(events))
        else $error("status bit not set by window event");

    // Output word holds without a new sample
    word_hold_a: assert property (
        !iq_valid |=> $stable(iq_out) && !out_valid)
        else $error("output word changed without a sample");

    high_trip_c: cover property (win_end && next_hi_flag);
    low_quiet_c: cover property (win_end && !next_lo_flag ##1 win_end);
    irq_rise_c:  cover property ($rose(irq));
    long_win_c:  cover property (win_end && window_exponent == 3'h7);
    apb_error_c: cover property (pready && pslverr);

endmodule

// File: rtl/ovr_pkg.sv
/*
 Types shared by the over-range detector: sample carriers and threshold type.
 Assumes nothing of its surroundings.
*/
package ovr_pkg;
    typedef logic [7:0] thr_t;

    // Complex 15-bit samples from the down converter
    typedef struct packed {
        logic [14:0] i;
        logic [14:0] q;
    } iq_s;

    // Complex output words with embedded flags
    typedef struct packed {
        logic [15:0] i_word;
        logic [15:0] q_word;
    } iq_word_s;
endpackage

// File: rtl/ovr_regs.svh
/*
 Holds the register map, field positions, reset values and fixed widths of the
 over-range detector. Assumes it is included by bare name from rtl/.
*/
// How it works
// - Every raw 12-bit sample's magnitude, upper 8 bits, meets two thresholds.
// - Offset binary read as two's complement; 11-bit magnitude, most negative saturates.
// - Flag is 1 when any magnitude in the window reaches its threshold.
// - High flag rides as LSB of each in-phase word over 15 sample bits.
// - Low flag rides as LSB of each quadrature word over 15 sample bits.
// - Window length is two to the power of the 3-bit exponent setting.
`ifndef OVR_REGS_SVH
`define OVR_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_INT_CLR   12'h008
`define OFS_INT_EN    12'h00C
`define OFS_FLAGS     12'h010

// ==========================================================
// Control fields
`define HI_THR_MSB    7
`define HI_THR_LSB    0
`define LO_THR_MSB    15
`define LO_THR_LSB    8
`define WEXP_MSB      18
`define WEXP_LSB      16
`define CTRL_RST      32'h0000_40E4
`define CTRL_MASK     32'h0007_FFFF

// ==========================================================
// Interrupt bits and misc constants
`define INT_W         2
`define INT_HI        0
`define INT_LO        1
`define INT_RST       2'h0
`define EXP_MAX       3'h7
`define MAG_FULL      11'h7FF
`define MAG_ZERO      11'h000
`define CNT_ONE       7'h01
`define WIN_MASK      7'h7F

`endif
